// ### hw/io_route_ctrl.sv
// Purpose: input word routing, interlock gating, open-drain output control and green/red status LEDs
// Assumes: all pins synchronous to CLK_SYS; registers reached over a plain strobe port
// Notes:   input word is rebuilt once per sample tick from debounced lines
`timescale 1ns/100ps

module io_route_ctrl
    import io_route_pkg::*;
#(
    parameter int NUM_OUTPUTS  = 2,
    parameter int SAMPLE_TICKS = SAMPLE_CYCLES,
    parameter int BLINK_TICKS  = BLINK_HALF_TICKS
) (
    // clock and reset
    input  wire logic                   CLK_SYS,
    input  wire logic                   RST_N,
    // register port
    input  wire logic [7:0]             REG_ADDR,
    input  wire logic [31:0]            REG_WDATA,
    input  wire logic                   REG_WR,
    input  wire logic                   REG_RD,
    output logic      [31:0]            REG_RDATA,
    // input lines
    input  wire logic [15:0]            PHYS_IN,
    input  wire logic                   ENC_A,
    input  wire logic                   ENC_B,
    input  wire logic                   ENC_INDEX,
    input  wire logic                   LINK_ACTIVE,
    // open-drain outputs
    output logic      [NUM_OUTPUTS-1:0] OUT_O,
    output logic      [NUM_OUTPUTS-1:0] OUT_OE,
    output logic                        BRAKE_O,
    output logic                        BRAKE_OE,
    // motion control
    output logic                        MOTION_PERMIT,
    output logic                        ERROR_STATE,
    output logic                        FAULT_REACTION_START,
    output logic      [15:0]            FAULT_REACTION,
    // indicators and interrupt
    output logic                        LED_GREEN,
    output logic                        LED_RED,
    output logic                        IRQ
);

    localparam int TICK_W  = $clog2(SAMPLE_TICKS + 1);
    localparam int BLINK_W = $clog2(BLINK_TICKS + 1);
    localparam logic [TICK_W-1:0]  TICK_LAST  = TICK_W'(SAMPLE_TICKS - 1);
    localparam logic [BLINK_W-1:0] BLINK_LAST = BLINK_W'(BLINK_TICKS - 1);

    typedef struct packed {
        logic [TICK_W-1:0]    tick_cnt;
        logic [BLINK_W-1:0]   blink_cnt;
        logic                 blink;
        in_lines_s            sample;
        in_lines_s            stable;
        logic [31:0]          input_word;
        logic [31:0][7:0]     route_sel;
        logic                 routing_en;
        logic [3:0]           special_en;
        out_cfg_s             out_cfg;
        logic [31:0]          applied;
        logic                 error;
        logic                 fault_start;
        logic [15:0]          fault_reaction;
        logic [1:0]           irq_status;
        logic [1:0]           irq_mask;
        logic [31:0]          rdata;
    } state_s;

    state_s s_q;
    state_s s_d;

    // one routed bit from its selector code
    function automatic logic route_bit(input logic [7:0] code, input in_lines_s lines);
        logic [6:0] base;
        logic       val;
        base = code[6:0];
        val  = 1'b0;
        if (base >= SRC_PHYS_FIRST && base <= SRC_PHYS_LAST) begin
            val = lines.phys[4'(base - SRC_PHYS_FIRST)];
        end else if (base == SRC_ENC_A) begin
            val = lines.enc_a;
        end else if (base == SRC_ENC_B) begin
            val = lines.enc_b;
        end else if (base == SRC_ENC_INDEX) begin
            val = lines.enc_index;
        end else if (base == SRC_LINK_ACTIVE) begin
            val = lines.link_active;
        end
        return val ^ code[SRC_INVERT_BIT];
    endfunction

    // masked write of one 32-bit register
    function automatic logic [31:0] reg_hit(input logic [7:0] addr, input logic [7:0] target);
        return {32{addr == target}};
    endfunction

    in_lines_s   lines_now;
    logic [31:0] routed;
    logic [31:0] level;
    logic        tick;
    logic        wr_route;
    logic [4:0]  route_idx;

    always_comb begin
        lines_now   = '{link_active: LINK_ACTIVE, enc_index: ENC_INDEX, enc_b: ENC_B,
                        enc_a: ENC_A, phys: PHYS_IN};
        tick        = (s_q.tick_cnt == TICK_LAST);
        wr_route    = REG_WR && (REG_ADDR >= ADDR_ROUTE_SELECT_BASE);
        route_idx   = REG_ADDR[6:2];
        for (int b = 0; b < 32; b++) begin
            routed[b] = route_bit(s_q.route_sel[b], s_q.stable);
        end
        level = (s_q.out_cfg.manual_en & s_q.out_cfg.manual_val)
              | (~s_q.out_cfg.manual_en & (s_q.out_cfg.word ^ s_q.out_cfg.polarity));
    end

    always_comb begin
        s_d             = s_q;
        s_d.fault_start = 1'b0;
        s_d.rdata       = '0;

        s_d.tick_cnt = tick ? '0 : TICK_W'(s_q.tick_cnt + 1'b1);
        if (tick) begin
            s_d.sample = lines_now;
            // only a level seen on two ticks is taken
            for (int b = 0; b < $bits(in_lines_s); b++) begin
                if (lines_now[b] == s_q.sample[b]) begin
                    s_d.stable[b] = s_q.sample[b];
                end
            end
            if (s_q.routing_en) begin
                s_d.input_word = routed;
            end else begin
                s_d.input_word = {s_q.stable.phys,
                                  12'h000, s_q.stable.phys[NUM_SPECIAL_INPUTS-1:0] & s_q.special_en};
            end
            if (s_d.input_word != s_q.input_word) begin
                s_d.irq_status[BIT_IRQ_INPUT_CHG] = 1'b1;
            end
            // gating only with special enable bit 3
            if (s_q.special_en[BIT_INTERLOCK] && !s_d.input_word[BIT_INTERLOCK] && !s_q.error) begin
                s_d.error                         = 1'b1;
                s_d.fault_start                   = 1'b1;
                s_d.irq_status[BIT_IRQ_INTERLOCK] = 1'b1;
            end
            s_d.blink_cnt = (s_q.blink_cnt == BLINK_LAST) ? '0 : BLINK_W'(s_q.blink_cnt + 1'b1);
            if (s_q.blink_cnt == BLINK_LAST) begin
                s_d.blink = ~s_q.blink;
            end
        end

        // brake at bit 0, outputs from bit 16, rest unassigned
        s_d.applied = '0;
        s_d.applied[BIT_BRAKE] = level[BIT_BRAKE];
        for (int n = 0; n < NUM_OUTPUTS; n++) begin
            s_d.applied[BIT_OUTPUT_FIRST + n] = level[BIT_OUTPUT_FIRST + n];
        end

        if (REG_WR) begin
            s_d.out_cfg.word       = (s_q.out_cfg.word & ~reg_hit(REG_ADDR, ADDR_OUTPUT_WORD))
                                   | (REG_WDATA & reg_hit(REG_ADDR, ADDR_OUTPUT_WORD));
            s_d.out_cfg.polarity   = (s_q.out_cfg.polarity & ~reg_hit(REG_ADDR, ADDR_OUTPUT_POLARITY))
                                   | (REG_WDATA & reg_hit(REG_ADDR, ADDR_OUTPUT_POLARITY));
            s_d.out_cfg.manual_en  = (s_q.out_cfg.manual_en & ~reg_hit(REG_ADDR, ADDR_OUTPUT_MANUAL_EN))
                                   | (REG_WDATA & reg_hit(REG_ADDR, ADDR_OUTPUT_MANUAL_EN));
            s_d.out_cfg.manual_val = (s_q.out_cfg.manual_val & ~reg_hit(REG_ADDR, ADDR_OUTPUT_MANUAL_VAL))
                                   | (REG_WDATA & reg_hit(REG_ADDR, ADDR_OUTPUT_MANUAL_VAL));
            s_d.out_cfg.routing_en = (s_q.out_cfg.routing_en & ~reg_hit(REG_ADDR, ADDR_OUTPUT_ROUTING_EN))
                                   | (REG_WDATA & reg_hit(REG_ADDR, ADDR_OUTPUT_ROUTING_EN));
            if (REG_ADDR == ADDR_LED_CONTROL) begin
                s_d.out_cfg.led = REG_WDATA[1:0];
            end
            if (REG_ADDR == ADDR_INPUT_ROUTING_EN) begin
                s_d.routing_en = REG_WDATA[0];
            end
            if (REG_ADDR == ADDR_SPECIAL_FUNC_EN) begin
                s_d.special_en = REG_WDATA[3:0];
            end
            if (REG_ADDR == ADDR_IRQ_MASK) begin
                s_d.irq_mask = REG_WDATA[1:0];
            end
            if (REG_ADDR == ADDR_FAULT_REACTION) begin
                s_d.fault_reaction = REG_WDATA[15:0];
            end
            // error leaves only once the release bit is back or the interlock is disabled
            if (REG_ADDR == ADDR_FAULT_CONTROL && REG_WDATA[BIT_FAULT_CLEAR] &&
                !(s_q.special_en[BIT_INTERLOCK] && !s_q.input_word[BIT_INTERLOCK]) && !s_d.fault_start) begin
                s_d.error = 1'b0;
            end
            // write one to clear; a same-cycle event wins only if its bit was clear
            if (REG_ADDR == ADDR_IRQ_STATUS) begin
                s_d.irq_status = (s_q.irq_status & ~REG_WDATA[1:0]) | (s_d.irq_status & ~s_q.irq_status);
            end
            if (wr_route) begin
                s_d.route_sel[route_idx] = REG_WDATA[7:0];
            end
        end

        if (REG_RD) begin
            if (REG_ADDR >= ADDR_ROUTE_SELECT_BASE) begin
                s_d.rdata = {24'h000000, s_q.route_sel[route_idx]};
            end else begin
                unique case (REG_ADDR)
                    ADDR_INPUT_WORD:        s_d.rdata = s_q.input_word;
                    ADDR_OUTPUT_WORD:       s_d.rdata = s_q.out_cfg.word;
                    ADDR_OUTPUT_POLARITY:   s_d.rdata = s_q.out_cfg.polarity;
                    ADDR_OUTPUT_MANUAL_EN:  s_d.rdata = s_q.out_cfg.manual_en;
                    ADDR_OUTPUT_MANUAL_VAL: s_d.rdata = s_q.out_cfg.manual_val;
                    ADDR_OUTPUT_APPLIED:    s_d.rdata = s_q.applied;
                    ADDR_OUTPUT_ROUTING_EN: s_d.rdata = s_q.out_cfg.routing_en;
                    ADDR_LED_CONTROL:       s_d.rdata = {30'h0, s_q.out_cfg.led};
                    ADDR_INPUT_ROUTING_EN:  s_d.rdata = {31'h0, s_q.routing_en};
                    ADDR_SPECIAL_FUNC_EN:   s_d.rdata = {28'h0, s_q.special_en};
                    ADDR_IRQ_STATUS:        s_d.rdata = {30'h0, s_q.irq_status};
                    ADDR_IRQ_MASK:          s_d.rdata = {30'h0, s_q.irq_mask};
                    ADDR_FAULT_REACTION:    s_d.rdata = {16'h0000, s_q.fault_reaction};
                    ADDR_FAULT_CONTROL:     s_d.rdata = {31'h0, s_q.error};
                    default:                s_d.rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s_q                <= '0;
            s_q.out_cfg        <= '{word: RESET_WORD, polarity: RESET_WORD, manual_en: RESET_WORD,
                                    manual_val: RESET_WORD, routing_en: RESET_WORD, led: 2'h0};
            s_q.route_sel      <= {32{RESET_ROUTE_SEL}};
            s_q.fault_reaction <= RESET_FAULT;
        end else begin
            s_q <= s_d;
        end
    end

    // open drain: a high level releases the pin, a low level pulls it
    always_comb begin
        for (int n = 0; n < NUM_OUTPUTS; n++) begin
            OUT_O[n]  = 1'b0;
            OUT_OE[n] = ~s_q.applied[BIT_OUTPUT_FIRST + n];
        end
        BRAKE_O              = 1'b0;
        BRAKE_OE             = ~s_q.applied[BIT_BRAKE];
        REG_RDATA            = s_q.rdata;
        MOTION_PERMIT        = !s_q.error &&
                               (!s_q.special_en[BIT_INTERLOCK] || s_q.input_word[BIT_INTERLOCK]);
        ERROR_STATE          = s_q.error;
        FAULT_REACTION_START = s_q.fault_start;
        FAULT_REACTION       = s_q.fault_reaction;
        LED_GREEN            = s_q.out_cfg.led[BIT_LED_GREEN] && !s_q.error && s_q.blink;
        LED_RED              = s_q.out_cfg.led[BIT_LED_RED] && s_q.error && s_q.blink;
        IRQ                  = |(s_q.irq_status & s_q.irq_mask);
    end

endmodule

// ### hw/io_route_pkg.sv
// Purpose: shared constants and carriers for the digital input routing and output control block
// Assumes: 100 MHz system clock, 32-bit register port with byte addresses
// Notes:   source codes, register offsets and timing counts are named here once
package io_route_pkg;

    // register byte addresses
    localparam logic [7:0] ADDR_INPUT_WORD          = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT_WORD         = 8'h04;
    localparam logic [7:0] ADDR_OUTPUT_POLARITY     = 8'h08;
    localparam logic [7:0] ADDR_OUTPUT_MANUAL_EN    = 8'h0c;
    localparam logic [7:0] ADDR_OUTPUT_MANUAL_VAL   = 8'h10;
    localparam logic [7:0] ADDR_OUTPUT_APPLIED      = 8'h14;
    localparam logic [7:0] ADDR_OUTPUT_ROUTING_EN   = 8'h18;
    localparam logic [7:0] ADDR_LED_CONTROL         = 8'h1c;
    localparam logic [7:0] ADDR_INPUT_ROUTING_EN    = 8'h20;
    localparam logic [7:0] ADDR_SPECIAL_FUNC_EN     = 8'h24;
    localparam logic [7:0] ADDR_IRQ_STATUS          = 8'h28;
    localparam logic [7:0] ADDR_IRQ_MASK            = 8'h2c;
    localparam logic [7:0] ADDR_OUTPUT_UNUSED       = 8'h30;
    localparam logic [7:0] ADDR_FAULT_REACTION      = 8'h34;
    localparam logic [7:0] ADDR_FAULT_CONTROL       = 8'h38;
    localparam logic [7:0] ADDR_ROUTE_SELECT_BASE   = 8'h80;

    // field positions
    localparam int BIT_INTERLOCK       = 3;
    localparam int BIT_BRAKE           = 0;
    localparam int BIT_OUTPUT_FIRST    = 16;
    localparam int BIT_LED_GREEN       = 0;
    localparam int BIT_LED_RED         = 1;
    localparam int BIT_IRQ_INTERLOCK   = 0;
    localparam int BIT_IRQ_INPUT_CHG   = 1;
    localparam int BIT_FAULT_CLEAR     = 0;
    localparam int NUM_SPECIAL_INPUTS  = 4;

    // source codes of the input router
    localparam logic [6:0] SRC_ZERO        = 7'h00;
    localparam logic [6:0] SRC_PHYS_FIRST  = 7'h01;
    localparam logic [6:0] SRC_PHYS_LAST   = 7'h10;
    localparam logic [6:0] SRC_ENC_A       = 7'h44;
    localparam logic [6:0] SRC_ENC_B       = 7'h45;
    localparam logic [6:0] SRC_ENC_INDEX   = 7'h46;
    localparam logic [6:0] SRC_LINK_ACTIVE = 7'h48;
    localparam int         SRC_INVERT_BIT  = 7;

    // reset values
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;
    localparam logic [7:0]  RESET_ROUTE_SEL = 8'h00;
    localparam logic [15:0] RESET_FAULT     = 16'h0000;

    // timing
    localparam int CLK_FREQ_MHZ      = 100;
    localparam int SAMPLE_PERIOD_US  = 1000;
    localparam int SAMPLE_CYCLES     = SAMPLE_PERIOD_US * CLK_FREQ_MHZ;
    localparam int BLINK_HALF_MS     = 250;
    localparam int BLINK_HALF_TICKS  = BLINK_HALF_MS * 1000 / SAMPLE_PERIOD_US;

    // sampled input lines
    typedef struct packed {
        logic        link_active;
        logic        enc_index;
        logic        enc_b;
        logic        enc_a;
        logic [15:0] phys;
    } in_lines_s;

    // output configuration
    typedef struct packed {
        logic [31:0] word;
        logic [31:0] polarity;
        logic [31:0] manual_en;
        logic [31:0] manual_val;
        logic [31:0] routing_en;
        logic [1:0]  led;
    } out_cfg_s;

endpackage

// ### bench/io_route_ctrl_asserts.sv
// Purpose: port level assertions for the routing and output control block
// Assumes: one clock, synchronous active-low reset
// Notes:   shadows of led control, interlock enable and sample tick follow the port
`timescale 1ns/100ps
module io_route_ctrl_asserts
    import io_route_pkg::*;
#(
    parameter int NUM_OUTPUTS  = 2,
    parameter int SAMPLE_TICKS = 8
) (
    // clock, reset and register writes
    input wire logic                   CLK_SYS,
    input wire logic                   RST_N,
    input wire logic [7:0]             REG_ADDR,
    input wire logic [31:0]            REG_WDATA,
    input wire logic                   REG_WR,
    // observed outputs
    input wire logic [NUM_OUTPUTS-1:0] OUT_OE,
    input wire logic                   BRAKE_OE,
    input wire logic                   MOTION_PERMIT,
    input wire logic                   ERROR_STATE,
    input wire logic                   FAULT_REACTION_START,
    input wire logic                   LED_GREEN,
    input wire logic                   LED_RED
);
    logic [1:0]  led_q;
    logic        ilk_q;
    logic [31:0] cnt_q;

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            led_q <= 2'h0;
            ilk_q <= 1'b0;
            cnt_q <= 32'h0;
        end else begin
            cnt_q <= (cnt_q == SAMPLE_TICKS - 1) ? 32'h0 : cnt_q + 32'h1;
            if (REG_WR && REG_ADDR == ADDR_LED_CONTROL) begin
                led_q <= REG_WDATA[1:0];
            end
            if (REG_WR && REG_ADDR == ADDR_SPECIAL_FUNC_EN) begin
                ilk_q <= REG_WDATA[BIT_INTERLOCK];
            end
        end
    end

    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);

    sequence s_err_entry;
        !ERROR_STATE ##1 ERROR_STATE;
    endsequence
    sequence s_clear_write;
        REG_WR && REG_ADDR == ADDR_FAULT_CONTROL && REG_WDATA[BIT_FAULT_CLEAR];
    endsequence

    property p_entry_pulse;
        s_err_entry |-> FAULT_REACTION_START ##1 !FAULT_REACTION_START;
    endproperty
    property p_error_halts;
        ERROR_STATE |-> !MOTION_PERMIT;
    endproperty
    property p_error_cleared;
        !ERROR_STATE ##0 $past(ERROR_STATE) |-> $past(REG_WR && REG_ADDR == ADDR_FAULT_CONTROL && REG_WDATA[0]);
    endproperty
    property p_no_gate;
        !ilk_q && !ERROR_STATE |-> MOTION_PERMIT;
    endproperty
    property p_start_enabled;
        FAULT_REACTION_START |-> $past(ilk_q);
    endproperty
    property p_start_tick;
        FAULT_REACTION_START |-> $past(cnt_q) == SAMPLE_TICKS - 1;
    endproperty
    property p_green_off;
        !led_q[BIT_LED_GREEN] && !$past(led_q[BIT_LED_GREEN]) |-> !LED_GREEN;
    endproperty
    property p_red_off;
        !led_q[BIT_LED_RED] && !$past(led_q[BIT_LED_RED]) |-> !LED_RED;
    endproperty
    property p_out_cause;
        !$stable(OUT_OE) |-> $past(REG_WR) || $past(REG_WR, 2);
    endproperty
    property p_brake_cause;
        !$stable(BRAKE_OE) |-> $past(REG_WR) || $past(REG_WR, 2);
    endproperty

    a_entry_pulse:   assert property (p_entry_pulse)   else $error("no single fault pulse at error entry");
    a_error_halts:   assert property (p_error_halts)   else $error("motion permitted in error");
    a_error_cleared: assert property (p_error_cleared) else $error("error left without clear write");
    a_no_gate:       assert property (p_no_gate)       else $error("motion gated without interlock");
    a_start_enabled: assert property (p_start_enabled) else $error("fault pulse with interlock off");
    a_start_tick:    assert property (p_start_tick)    else $error("fault pulse off sample tick");
    a_green_off:     assert property (p_green_off)     else $error("green lit while disabled");
    a_red_off:       assert property (p_red_off)       else $error("red lit while disabled");
    a_out_cause:     assert property (p_out_cause)     else $error("output moved without write");
    a_brake_cause:   assert property (p_brake_cause)   else $error("brake moved without write");
    c_clear:         cover property (s_clear_write);
endmodule

bind io_route_ctrl io_route_ctrl_asserts #(.NUM_OUTPUTS(NUM_OUTPUTS), .SAMPLE_TICKS(SAMPLE_TICKS)) i_io_route_ctrl_asserts (
    .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .OUT_OE(OUT_OE), .BRAKE_OE(BRAKE_OE), .MOTION_PERMIT(MOTION_PERMIT), .ERROR_STATE(ERROR_STATE),
    .FAULT_REACTION_START(FAULT_REACTION_START), .LED_GREEN(LED_GREEN), .LED_RED(LED_RED));

// ### bench/io_field_model.sv
// Purpose: switches, encoder lines and pulled-up open-drain loads
// Assumes: lines change right after a clock edge
// Notes:   a released pin reads high through its pull-up
`timescale 1ns/100ps
module io_field_model
    import io_route_pkg::*;
#(
    parameter int NUM_OUTPUTS = 2
) (
    // clock and wanted line levels
    input  wire logic                   CLK_SYS,
    input  wire in_lines_s              want,
    // open-drain enables
    input  wire logic [NUM_OUTPUTS-1:0] OUT_OE,
    input  wire logic                   BRAKE_OE,
    // lines and pin levels
    output in_lines_s                   lines,
    output logic      [NUM_OUTPUTS-1:0] out_pin,
    output logic                        brake_pin
);
    always_ff @(posedge CLK_SYS) begin
        lines <= want;
    end
    assign out_pin   = ~OUT_OE;
    assign brake_pin = ~BRAKE_OE;
endmodule

// ### bench/io_routing_and_output_control_test.sv
// Purpose: self-checking bench for the routing and output control block
// Assumes: short sample tick and blink counts
// Notes:   read results are matched against a queue of notes
`timescale 1ns/100ps
module io_routing_and_output_control_test;
    import io_route_pkg::*;
    localparam int ST = 8;
    logic        CLK_SYS, RST_N = 1'b0, REG_WR = 1'b0, REG_RD = 1'b0, rd_pend = 1'b0;
    logic [7:0]  REG_ADDR = 8'h0;
    logic [31:0] REG_WDATA = 32'h0, REG_RDATA, rs = 32'hf866cf20;
    logic [1:0]  OUT_O, OUT_OE, out_pin;
    logic        BRAKE_O, BRAKE_OE, brake_pin, MOTION_PERMIT, ERROR_STATE, FAULT_REACTION_START;
    logic        LED_GREEN, LED_RED, IRQ;
    logic [15:0] FAULT_REACTION;
    in_lines_s   want = '0, lines;
    logic [63:0] exp_q[$];
    int          failures = 0, total_checks = 0;
    logic [7:0]  codes [16] = '{8'h00, 8'h01, 8'h10, 8'h44, 8'h45, 8'h46, 8'h48, 8'h80,
                                8'h81, 8'h90, 8'hc4, 8'hc5, 8'hc6, 8'hc8, 8'h20, 8'ha0};
    logic [7:0]  rw_a [10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h2c, 8'h34};
    logic [31:0] rw_m [10] = '{'1, '1, '1, '1, '1, 32'h3, 32'h1, 32'h7, 32'h3, 32'hffff};

    io_route_ctrl #(.NUM_OUTPUTS(2), .SAMPLE_TICKS(ST), .BLINK_TICKS(2)) i_io_route_ctrl (
        .CLK_SYS(CLK_SYS), .RST_N(RST_N), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .PHYS_IN(lines.phys), .ENC_A(lines.enc_a), .ENC_B(lines.enc_b),
        .ENC_INDEX(lines.enc_index), .LINK_ACTIVE(lines.link_active), .OUT_O(OUT_O), .OUT_OE(OUT_OE),
        .BRAKE_O(BRAKE_O), .BRAKE_OE(BRAKE_OE), .MOTION_PERMIT(MOTION_PERMIT), .ERROR_STATE(ERROR_STATE),
        .FAULT_REACTION_START(FAULT_REACTION_START), .FAULT_REACTION(FAULT_REACTION),
        .LED_GREEN(LED_GREEN), .LED_RED(LED_RED), .IRQ(IRQ));
    io_field_model #(.NUM_OUTPUTS(2)) i_io_field_model (.CLK_SYS(CLK_SYS), .want(want), .OUT_OE(OUT_OE),
        .BRAKE_OE(BRAKE_OE), .lines(lines), .out_pin(out_pin), .brake_pin(brake_pin));

    function logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction
    function automatic logic src(input logic [7:0] c, input in_lines_s l);
        logic v;
        v = 1'b0;
        if (c[6:0] >= SRC_PHYS_FIRST && c[6:0] <= SRC_PHYS_LAST) v = l.phys[4'(c[6:0] - 7'h1)];
        if (c[6:0] == SRC_ENC_A) v = l.enc_a;
        if (c[6:0] == SRC_ENC_B) v = l.enc_b;
        if (c[6:0] == SRC_ENC_INDEX) v = l.enc_index;
        if (c[6:0] == SRC_LINK_ACTIVE) v = l.link_active;
        return v ^ c[SRC_INVERT_BIT];
    endfunction
    task automatic chk_word(input logic [31:0] got, input logic [63:0] e);
        total_checks++;
        if ((got & e[63:32]) !== e[31:0]) begin
            failures++;
            $display("[FAIL] %0t read %h expected %h", $time, got, e[31:0]);
        end
    endtask
    task automatic chk_bit(input logic got, input logic e);
        total_checks++;
        if (got !== e) begin
            failures++;
            $display("[FAIL] %0t pin %b expected %b", $time, got, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK_SYS);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        exp_q.push_back({m, e & m});
        @(posedge CLK_SYS);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
    endtask
    task set_lines(input in_lines_s l, input int n);
        @(posedge CLK_SYS);
        want <= l;
        repeat (n) @(posedge CLK_SYS);
    endtask
    task final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    initial begin
        CLK_SYS = 1'b0;
        forever #5 CLK_SYS = ~CLK_SYS;
    end
    always @(posedge CLK_SYS) begin
        if (rd_pend) begin
            chk_word(REG_RDATA, exp_q.pop_front());
        end
        rd_pend <= REG_RD;
    end
    initial begin
        #500us;
        failures++;
        final_report();
    end

    initial begin
        logic [31:0] v [4];
        logic [31:0] e;
        in_lines_s   l;
        int          i;
        int          k;
        repeat (4) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        for (k = 0; k < 17; k++) rd(8'(k * 4), 32'h0, '1);
        for (k = 0; k < 10; k++) begin
            e = rnd() & rw_m[k];
            wr(rw_a[k], e);
            rd(rw_a[k], e, '1);
        end
        chk_word({16'h0, FAULT_REACTION}, {32'hffffffff, e});
        for (k = 0; k < 10; k++) wr(rw_a[k], 32'h0);
        wr(ADDR_IRQ_STATUS, 32'h3);
        wr(ADDR_OUTPUT_APPLIED, '1);
        wr(ADDR_INPUT_WORD, '1);
        wr(8'h40, '1);
        rd(ADDR_OUTPUT_APPLIED, 32'h0, '1);
        rd(ADDR_INPUT_WORD, 32'h0, '1);
        rd(8'h40, 32'h0, '1);
        $display("register map test done");
        for (i = 0; i < 6; i++) begin
            for (k = 0; k < 4; k++) begin
                v[k] = rnd();
                wr(ADDR_OUTPUT_WORD + 8'(4 * k), v[k]);
            end
            e = (v[2] & v[3]) | (~v[2] & (v[0] ^ v[1]));
            rd(ADDR_OUTPUT_APPLIED, e, 32'h00030001);
            @(posedge CLK_SYS);
            chk_bit(out_pin[0], e[BIT_OUTPUT_FIRST]);
            chk_bit(out_pin[1], e[BIT_OUTPUT_FIRST + 1]);
            chk_bit(brake_pin, e[BIT_BRAKE]);
            chk_bit(|{OUT_O, BRAKE_O}, 1'b0);
        end
        $display("output control test done");
        wr(ADDR_INPUT_ROUTING_EN, 32'h1);
        for (k = 0; k < 16; k++) wr(ADDR_ROUTE_SELECT_BASE + 8'(4 * k), {24'h0, codes[k]});
        for (i = 0; i < 3; i++) begin
            e = rnd();
            l = e[19:0];
            set_lines(l, 4 * ST);
            e = 32'h0;
            for (k = 0; k < 16; k++) e[k] = src(codes[k], l);
            rd(ADDR_INPUT_WORD, e, '1);
        end
        wr(ADDR_IRQ_STATUS, 32'h3);
        set_lines(~l, ST / 2);
        set_lines(l, 4 * ST);
        rd(ADDR_INPUT_WORD, e, '1);
        rd(ADDR_IRQ_STATUS, 32'h0, '1);
        wr(ADDR_INPUT_ROUTING_EN, 32'h0);
        repeat (4 * ST) @(posedge CLK_SYS);
        rd(ADDR_INPUT_WORD, {l.phys, 16'h0}, '1);
        $display("input routing test done");
        wr(ADDR_INPUT_ROUTING_EN, 32'h1);
        wr(ADDR_ROUTE_SELECT_BASE + 8'h0c, 32'h04);
        l = '0;
        l.phys[3] = 1'b1;
        set_lines(l, 4 * ST);
        wr(ADDR_IRQ_STATUS, 32'h3);
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_SPECIAL_FUNC_EN, 32'h8);
        repeat (2 * ST) @(posedge CLK_SYS);
        chk_bit(MOTION_PERMIT, 1'b1);
        chk_bit(ERROR_STATE, 1'b0);
        set_lines('0, 0);
        for (k = 0; k < 6 * ST && ERROR_STATE !== 1'b1; k++) @(posedge CLK_SYS);
        chk_bit(ERROR_STATE, 1'b1);
        chk_bit(MOTION_PERMIT, 1'b0);
        rd(ADDR_FAULT_CONTROL, 32'h1, 32'h1);
        chk_bit(IRQ, 1'b1);
        // red flashes only while in error
        wr(ADDR_LED_CONTROL, 32'h2);
        i = 0;
        for (k = 0; k < 8 * ST; k++) @(posedge CLK_SYS) i += int'(LED_RED === 1'b1);
        chk_bit(i > 0 && i < 8 * ST, 1'b1);
        chk_bit(LED_GREEN, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h0);
        repeat (2) @(posedge CLK_SYS);
        chk_bit(IRQ, 1'b0);
        wr(ADDR_IRQ_MASK, 32'h1);
        wr(ADDR_IRQ_STATUS, 32'h1);
        repeat (2) @(posedge CLK_SYS);
        chk_bit(IRQ, 1'b0);
        set_lines(l, 4 * ST);
        chk_bit(ERROR_STATE, 1'b1);
        wr(ADDR_FAULT_CONTROL, 32'h1);
        repeat (2) @(posedge CLK_SYS);
        chk_bit(ERROR_STATE, 1'b0);
        chk_bit(MOTION_PERMIT, 1'b1);
        wr(ADDR_SPECIAL_FUNC_EN, 32'h0);
        set_lines('0, 4 * ST);
        chk_bit(ERROR_STATE, 1'b0);
        chk_bit(MOTION_PERMIT, 1'b1);
        $display("interlock test done");
        wr(ADDR_LED_CONTROL, 32'h1);
        i = 0;
        for (k = 0; k < 8 * ST; k++) begin
            @(posedge CLK_SYS);
            i += int'(LED_GREEN === 1'b1);
        end
        chk_bit(i > 0 && i < 8 * ST, 1'b1);
        chk_bit(LED_RED, 1'b0);
        $display("led test done");
        final_report();
    end
endmodule
